// ==== src/core_integration_pkg.sv ====
// constants shared by the processor-core integration wrapper
// Functional notes
// - exactly 37 peripheral interrupt lines reach core
// - interrupt line count field reads 00001
// - three implemented priority bits everywhere
// - tick reference is oscillator input divided by 32
// - tick calibration reload fixed at 0x9C4
// - no-reference and inexact flags read zero
// - core reset request triggers full system reset
// - core_signal_a unused; only interrupt or reset exits
// - auxiliary fault status always reads zero
// - event input and output left unconnected
// - deep-sleep indication unused, never granted
// - no exclusive-access monitor on data bus
// - trace leaves via trace pin and viewer
// - one trace data, one trace clock, viewer
// - debug port: probe clock, bidirectional data
// - watchdog stops while core halted by debugger
package core_integration_pkg;
  localparam int IRQ_COUNT = 37;
  localparam int IRQ_INDEX_W = 6;
  localparam logic [4:0] INTERRUPT_LINE_COUNT_VALUE = 5'h01;
  localparam int PRIORITY_BITS = 3;
  localparam int PRIORITY_FIELD_W = 8;
  localparam int PRIORITY_LSB = PRIORITY_FIELD_W - PRIORITY_BITS;
  localparam int TICK_REF_DIVIDE = 32;
  localparam logic [23:0] TICK_CAL_RELOAD = 24'h0009C4;
  localparam int TICK_CAL_INTERVAL_MS = 10;
  localparam int TICK_CAL_OSC_KHZ = 8000;
  localparam int CAL_NO_REF_POS = 31;
  localparam int CAL_INEXACT_POS = 30;
  localparam logic [31:0] AUX_FAULT_STATUS_VALUE = 32'h00000000;
  localparam int SYS_RESET_HOLD_CYCLES = 16;
  localparam int RESET_CNT_W = 5;
  localparam logic [RESET_CNT_W-1:0] RESET_CNT_RESET = 5'h00;
  localparam logic [PRIORITY_FIELD_W-1:0] PRIORITY_READ_RESET = 8'h00;
endpackage

// ==== src/tick_reference_divider.sv ====
// divides the synchronised oscillator input into a tick reference pulse
module tick_reference_divider #(
  parameter int DIVIDE = core_integration_pkg::TICK_REF_DIVIDE
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // oscillator level, already synchronised
  input wire logic i_osc_level,
  // one pulse per DIVIDE oscillator periods
  output logic o_tick_pulse
);
  import core_integration_pkg::*;
  localparam int CNT_W = $clog2(DIVIDE);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIVIDE - 1);

  logic osc_prev_reg;
  logic [CNT_W-1:0] edge_cnt_reg;
  logic osc_rise;

  assign osc_rise = i_osc_level && !osc_prev_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= i_osc_level;
    end
  end

  // counts oscillator rising edges; pulse marks every DIVIDE-th one
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      edge_cnt_reg <= '0;
      o_tick_pulse <= 1'b0;
    end else begin
      o_tick_pulse <= osc_rise && (edge_cnt_reg == CNT_LAST);
      if (osc_rise) begin
        edge_cnt_reg <= (edge_cnt_reg == CNT_LAST) ? '0 : edge_cnt_reg + 1'b1;
      end
    end
  end

  // each oscillator edge needs at least two core cycles, so pulses are far apart
  a_tick_spacing: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_tick_pulse |=> !o_tick_pulse [*8])
    else $error("tick reference pulses too close together");
endmodule // tick_reference_divider

// ==== src/core_integration_config.sv ====
// tie-offs and glue around the processor core: interrupts, tick, reset, debug, trace
module core_integration_config (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // peripheral interrupt requests and the core's view of them
  input wire logic [core_integration_pkg::IRQ_COUNT-1:0] i_irq_lines,
  output logic [core_integration_pkg::IRQ_COUNT-1:0] o_core_irq,
  output logic [4:0] o_interrupt_line_count_field,
  // non-maskable interrupt pin
  input wire logic i_nmi_pin,
  output logic o_core_nmi,
  // priority field access from the core
  input wire logic i_prio_wr_en,
  input wire logic [core_integration_pkg::IRQ_INDEX_W-1:0] i_prio_wr_index,
  input wire logic [core_integration_pkg::PRIORITY_FIELD_W-1:0] i_prio_wr_data,
  input wire logic [core_integration_pkg::IRQ_INDEX_W-1:0] i_prio_rd_index,
  output logic [core_integration_pkg::PRIORITY_FIELD_W-1:0] o_prio_rd_data,
  // tick timer reference and calibration
  input wire logic i_high_speed_osc_input,
  output logic o_tick_ref_pulse,
  output logic [31:0] o_tick_calibration,
  // reset request and fixed core status
  input wire logic i_system_reset_request,
  output logic o_sys_reset,
  output logic [31:0] o_aux_fault_status,
  output logic o_core_event_in,
  output logic o_deep_sleep_grant,
  output logic o_exclusive_okay,
  // debug wire port
  input wire logic i_debug_wire_clock,
  input wire logic i_debug_data_in,
  output logic o_debug_data_out,
  output logic o_debug_data_oe,
  output logic o_core_debug_clock,
  output logic o_core_debug_data_in,
  input wire logic i_core_debug_data_out,
  input wire logic i_core_debug_data_oe,
  // trace from the core to the pins
  input wire logic i_core_trace_data,
  input wire logic i_core_viewer_data,
  output logic o_trace_data_pin,
  output logic o_trace_clock_pin,
  output logic o_serial_viewer_output,
  // debug halt and watchdog
  input wire logic i_core_halted,
  output logic o_watchdog_stop
);
  import core_integration_pkg::*;

  logic [PRIORITY_BITS-1:0] prio_mem [IRQ_COUNT];
  logic [1:0] osc_sync_reg;
  logic [1:0] nmi_sync_reg;
  logic [1:0] dbg_clk_sync_reg;
  logic [1:0] dbg_data_sync_reg;
  logic [RESET_CNT_W-1:0] reset_cnt_reg;
  logic trace_phase_reg;
  logic [IRQ_INDEX_W-1:0] wr_index_d_reg;
  logic [PRIORITY_BITS-1:0] wr_top_d_reg;
  logic wr_valid_d_reg;

  function automatic logic index_valid(input logic [IRQ_INDEX_W-1:0] idx);
    return idx < IRQ_INDEX_W'(IRQ_COUNT);
  endfunction

  // only the implemented top bits survive; the rest read back as zero
  function automatic logic [PRIORITY_FIELD_W-1:0] widen_priority(input logic [PRIORITY_BITS-1:0] top);
    return {top, {PRIORITY_LSB{1'b0}}};
  endfunction

  // fixed configuration values
  assign o_interrupt_line_count_field = INTERRUPT_LINE_COUNT_VALUE;
  assign o_aux_fault_status = AUX_FAULT_STATUS_VALUE;
  assign o_core_event_in = 1'b0;
  assign o_deep_sleep_grant = 1'b0;
  assign o_exclusive_okay = 1'b0;

  always_comb begin
    o_tick_calibration = {8'h00, TICK_CAL_RELOAD};
    o_tick_calibration[CAL_NO_REF_POS] = 1'b0;
    o_tick_calibration[CAL_INEXACT_POS] = 1'b0;
  end

  // interrupt lines come from same-clock peripherals; one register stage only
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_core_irq <= '0;
    end else begin
      o_core_irq <= i_irq_lines;
    end
  end

  // core_signal_a is not watched; the pin interrupt is the software-free way out
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      nmi_sync_reg <= 2'h0;
    end else begin
      nmi_sync_reg <= {nmi_sync_reg[0], i_nmi_pin};
    end
  end
  assign o_core_nmi = nmi_sync_reg[1];

  // priority storage keeps only the implemented bits
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      for (int i = 0; i < IRQ_COUNT; i++) begin
        prio_mem[i] <= '0;
      end
    end else if (i_prio_wr_en && index_valid(i_prio_wr_index)) begin
      prio_mem[i_prio_wr_index] <= i_prio_wr_data[PRIORITY_FIELD_W-1:PRIORITY_LSB];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_prio_rd_data <= PRIORITY_READ_RESET;
    end else if (index_valid(i_prio_rd_index)) begin
      o_prio_rd_data <= widen_priority(prio_mem[i_prio_rd_index]);
    end else begin
      o_prio_rd_data <= PRIORITY_READ_RESET;
    end
  end

  // helper copy of the last write for checking
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      wr_valid_d_reg <= 1'b0;
      wr_index_d_reg <= '0;
      wr_top_d_reg <= '0;
    end else begin
      wr_valid_d_reg <= i_prio_wr_en && index_valid(i_prio_wr_index);
      wr_index_d_reg <= i_prio_wr_index;
      wr_top_d_reg <= i_prio_wr_data[PRIORITY_FIELD_W-1:PRIORITY_LSB];
    end
  end

  // oscillator pin is asynchronous to the core clock
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      osc_sync_reg <= 2'h0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], i_high_speed_osc_input};
    end
  end

  tick_reference_divider #(
    .DIVIDE(TICK_REF_DIVIDE)
  ) u_tick_div (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_osc_level(osc_sync_reg[1]),
    .o_tick_pulse(o_tick_ref_pulse)
  );

  // the request is stretched so the whole system sees a clean reset;
  // low-speed mode is not guarded here, software must keep clear of it
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      reset_cnt_reg <= RESET_CNT_RESET;
    end else if (i_system_reset_request && reset_cnt_reg == RESET_CNT_RESET) begin
      reset_cnt_reg <= RESET_CNT_W'(SYS_RESET_HOLD_CYCLES);
    end else if (reset_cnt_reg != RESET_CNT_RESET) begin
      reset_cnt_reg <= reset_cnt_reg - 1'b1;
    end
  end
  assign o_sys_reset = reset_cnt_reg != RESET_CNT_RESET;

  // probe clock and data are pins, so both pass two flip-flops
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      dbg_clk_sync_reg <= 2'h0;
      dbg_data_sync_reg <= 2'h0;
    end else begin
      dbg_clk_sync_reg <= {dbg_clk_sync_reg[0], i_debug_wire_clock};
      dbg_data_sync_reg <= {dbg_data_sync_reg[0], i_debug_data_in};
    end
  end
  assign o_core_debug_clock = dbg_clk_sync_reg[1];
  assign o_core_debug_data_in = dbg_data_sync_reg[1];

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_debug_data_out <= 1'b0;
      o_debug_data_oe <= 1'b0;
    end else begin
      o_debug_data_out <= i_core_debug_data_out;
      o_debug_data_oe <= i_core_debug_data_oe;
    end
  end

  // trace clock is the core clock halved; data changes on its falling edge
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      trace_phase_reg <= 1'b0;
      o_trace_data_pin <= 1'b0;
      o_serial_viewer_output <= 1'b0;
    end else begin
      trace_phase_reg <= !trace_phase_reg;
      if (trace_phase_reg) begin
        o_trace_data_pin <= i_core_trace_data;
      end
      o_serial_viewer_output <= i_core_viewer_data;
    end
  end
  assign o_trace_clock_pin = trace_phase_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_watchdog_stop <= 1'b0;
    end else begin
      o_watchdog_stop <= i_core_halted;
    end
  end

  a_irq_forward: assert property (@(posedge i_core_clk) disable iff (i_srst)
    1'b1 |=> o_core_irq == $past(i_irq_lines))
    else $error("interrupt lines not forwarded to core");

  a_line_count_fixed: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_interrupt_line_count_field == 5'h01 && ($past(i_srst) || o_core_irq == $past(i_irq_lines)))
    else $error("interrupt line count field wrong");

  a_prio_low_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_prio_rd_data[PRIORITY_LSB-1:0] == '0)
    else $error("unimplemented priority bits not zero");

  a_prio_write_kept: assert property (@(posedge i_core_clk) disable iff (i_srst)
    wr_valid_d_reg && !i_prio_wr_en && i_prio_rd_index == wr_index_d_reg
    |=> o_prio_rd_data == widen_priority($past(wr_top_d_reg)))
    else $error("priority write not read back");

  a_cal_value: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_tick_calibration[23:0] == 24'h0009C4)
    else $error("calibration reload wrong");

  a_cal_flags_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_tick_calibration[CAL_NO_REF_POS] && !o_tick_calibration[CAL_INEXACT_POS])
    else $error("calibration flags not zero");

  a_reset_stretch: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_system_reset_request && !o_sys_reset |=> o_sys_reset [*8] ##1 o_sys_reset [*8] ##1 !o_sys_reset)
    else $error("system reset not held for the stretch length");

  a_aux_event_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_aux_fault_status == 32'h00000000 && !o_core_event_in && !o_deep_sleep_grant)
    else $error("fixed core status not zero");

  a_debug_drive: assert property (@(posedge i_core_clk) disable iff (i_srst)
    1'b1 |=> o_debug_data_oe == $past(i_core_debug_data_oe) && o_debug_data_out == $past(i_core_debug_data_out))
    else $error("debug data pin not driven from core");

  a_trace_stable: assert property (@(posedge i_core_clk) disable iff (i_srst)
    !o_trace_clock_pin |=> $stable(o_trace_data_pin) && o_trace_clock_pin)
    else $error("trace data changed with trace clock high");

  a_watchdog_halt: assert property (@(posedge i_core_clk) disable iff (i_srst)
    i_core_halted [*2] |=> o_watchdog_stop && $past(o_watchdog_stop))
    else $error("watchdog not stopped while halted");
endmodule // core_integration_config

// ==== verif/core_probe_model.sv ====
// behavioural processor core and debug probe facing the integration wrapper
module core_probe_model (
  // clock
  input wire logic i_clk,
  // scenario control
  input wire logic i_active,
  input wire logic i_reset_req,
  input wire logic i_dev_oe,
  // core side
  output logic o_reset_request,
  output logic o_trace_data,
  output logic o_viewer_data,
  output logic o_dbg_out,
  output logic o_dbg_oe,
  output logic o_halted,
  // probe side
  output logic o_wire_clock,
  output logic o_wire_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic probe_oe, probe_data;
  // the core model has no deep-sleep or event pins at all
  // requests come only when the bench asks; low-speed mode is never modelled
  assign o_reset_request = i_reset_req;
  // probe backs off while the device drives; a released line floats to its pull-up
  assign o_wire_level = (probe_oe && !i_dev_oe) ? probe_data : 1'b1;
  initial begin
    {o_trace_data, o_viewer_data, o_dbg_out, o_dbg_oe, o_halted, o_wire_clock} = 6'h00;
    {probe_oe, probe_data} = 2'h0;
  end
  always @(negedge i_clk) begin
    if (i_active) begin
      // probe clock only runs while traffic is wanted, else it holds its last level
      o_wire_clock <= ~o_wire_clock;
      {o_trace_data, o_viewer_data, o_dbg_out, o_dbg_oe, o_halted} <= 5'($urandom);
      {probe_oe, probe_data} <= 2'($urandom);
    end
  end
endmodule // core_probe_model

// ==== verif/core_integration_config_tb.sv ====
// self-checking bench for the core integration wrapper
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module core_integration_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import core_integration_pkg::*;
  typedef struct {int due; int id; logic [36:0] v;} note_type;
  localparam logic [71:0] FIXED = {5'h01, 32'h000009C4, 32'h00000000, 3'h0};
  logic clk, srst, nmi, wr_en, osc, act, rq, wire_lvl, live, tclk_prev, trs;
  logic [36:0] irq;
  logic [5:0] wr_idx, rd_idx;
  logic [7:0] wr_data;
  logic [7:0] prio_m [64];
  logic m_req, m_tr, m_vw, m_dout, m_doe, m_halt, m_wclk, m_wlvl;
  logic [36:0] o_core_irq;
  logic [4:0] o_interrupt_line_count_field;
  logic [7:0] o_prio_rd_data;
  logic [31:0] o_tick_calibration, o_aux_fault_status;
  logic o_core_nmi, o_tick_ref_pulse, o_sys_reset, o_core_event_in, o_deep_sleep_grant, o_exclusive_okay;
  logic o_debug_data_out, o_debug_data_oe, o_core_debug_clock, o_core_debug_data_in;
  logic o_trace_data_pin, o_trace_clock_pin, o_serial_viewer_output, o_watchdog_stop;
  logic [71:0] fixed_seen;
  note_type q[$];
  int cyc = 0, rcnt = 0, ticks = 0, fail_count = 0, total_checks = 0;
  assign fixed_seen = {o_interrupt_line_count_field, o_tick_calibration, o_aux_fault_status,
                       o_core_event_in, o_deep_sleep_grant, o_exclusive_okay};
  assign wire_lvl = o_debug_data_oe ? o_debug_data_out : m_wlvl;
  core_integration_config dut (.i_core_clk(clk), .i_srst(srst), .i_irq_lines(irq), .o_core_irq(o_core_irq),
    .o_interrupt_line_count_field(o_interrupt_line_count_field), .i_nmi_pin(nmi), .o_core_nmi(o_core_nmi),
    .i_prio_wr_en(wr_en), .i_prio_wr_index(wr_idx), .i_prio_wr_data(wr_data), .i_prio_rd_index(rd_idx),
    .o_prio_rd_data(o_prio_rd_data), .i_high_speed_osc_input(osc), .o_tick_ref_pulse(o_tick_ref_pulse),
    .o_tick_calibration(o_tick_calibration), .i_system_reset_request(m_req), .o_sys_reset(o_sys_reset),
    .o_aux_fault_status(o_aux_fault_status), .o_core_event_in(o_core_event_in),
    .o_deep_sleep_grant(o_deep_sleep_grant), .o_exclusive_okay(o_exclusive_okay),
    .i_debug_wire_clock(m_wclk), .i_debug_data_in(wire_lvl), .o_debug_data_out(o_debug_data_out),
    .o_debug_data_oe(o_debug_data_oe), .o_core_debug_clock(o_core_debug_clock),
    .o_core_debug_data_in(o_core_debug_data_in), .i_core_debug_data_out(m_dout), .i_core_debug_data_oe(m_doe),
    .i_core_trace_data(m_tr), .i_core_viewer_data(m_vw), .o_trace_data_pin(o_trace_data_pin),
    .o_trace_clock_pin(o_trace_clock_pin), .o_serial_viewer_output(o_serial_viewer_output),
    .i_core_halted(m_halt), .o_watchdog_stop(o_watchdog_stop));
  core_probe_model partner (.i_clk(clk), .i_active(act), .i_reset_req(rq), .i_dev_oe(o_debug_data_oe),
    .o_reset_request(m_req), .o_trace_data(m_tr), .o_viewer_data(m_vw), .o_dbg_out(m_dout), .o_dbg_oe(m_doe),
    .o_halted(m_halt), .o_wire_clock(m_wclk), .o_wire_level(m_wlvl));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check_note(note_type n);
    case (n.id)
      0: `CHK("irq", n.v, o_core_irq)
      1: `CHK("nmi", n.v, o_core_nmi)
      2: `CHK("wdog_stop", n.v, o_watchdog_stop)
      3: `CHK("viewer", n.v, o_serial_viewer_output)
      4: `CHK("dbg_out", n.v, {o_debug_data_out, o_debug_data_oe})
      5: `CHK("dbg_in", n.v, {o_core_debug_clock, o_core_debug_data_in})
      6: `CHK("prio_rd", n.v, o_prio_rd_data)
      default: `CHK("sys_reset", n.v, o_sys_reset)
    endcase
  endtask
  // inputs are read here before the edge's own updates land, so they are what the flops saw
  always @(posedge clk) begin
    cyc++;
    live = !srst;
    trs = m_tr;
    if (cyc >= 3000) begin
      fail_count++;
      report_and_stop();
    end else if (live) begin
      q.push_back('{cyc, 0, irq});
      q.push_back('{cyc + 1, 1, 37'(nmi)});
      q.push_back('{cyc, 2, 37'(m_halt)});
      q.push_back('{cyc, 3, 37'(m_vw)});
      q.push_back('{cyc, 4, 37'({m_dout, m_doe})});
      q.push_back('{cyc + 1, 5, 37'({m_wclk, wire_lvl})});
      q.push_back('{cyc, 6, 37'((rd_idx < IRQ_COUNT) ? {prio_m[rd_idx][7:5], 5'h00} : 8'h00)});
      if (wr_en && wr_idx < IRQ_COUNT) prio_m[wr_idx] = wr_data;
      if (rcnt > 0) rcnt--;
      else if (m_req) begin
        for (int i = 0; i < 17; i++) q.push_back('{cyc + i, 7, 37'(i < 16)});
        rcnt = 16;
      end
    end
  end
  always @(negedge clk) begin
    for (int i = q.size() - 1; i >= 0; i--) begin
      if (q[i].due == cyc) begin
        check_note(q[i]);
        q.delete(i);
      end
    end
    if (live) begin
      `CHK("fixed", FIXED, fixed_seen)
      `CHK("trace_clk", ~tclk_prev, o_trace_clock_pin)
      if (tclk_prev === 1'b1) `CHK("trace_data", trs, o_trace_data_pin)
    end
    if (o_tick_ref_pulse === 1'b1) ticks++;
    tclk_prev = o_trace_clock_pin;
  end
  initial begin
    void'($urandom(32'h1F1A));
    {srst, nmi, wr_en, osc, act, rq} = 6'h20;
    {irq, wr_idx, rd_idx, wr_data} = '0;
    foreach (prio_m[i]) prio_m[i] = 8'h00;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    // three reference pulses need exactly 96 oscillator rising edges
    repeat (96) begin
      repeat (2) @(negedge clk);
      osc = 1'b1;
      repeat (2) @(negedge clk);
      osc = 1'b0;
    end
    repeat (6) @(posedge clk);
    `CHK("ticks", 3, ticks)
    act = 1'b1;
    repeat (300) begin
      @(negedge clk);
      irq = 37'({$urandom, $urandom});
      nmi = 1'($urandom);
      rd_idx = 6'($urandom);
    end
    // back-to-back writes over every index, the unimplemented ones included
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      {wr_en, wr_idx, wr_data} = {1'b1, 6'(i), 8'($urandom)};
    end
    @(negedge clk);
    wr_en = 1'b0;
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      rd_idx = 6'(i);
    end
    // a write read back in the very next cycle, as the core would do
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {wr_en, wr_idx, wr_data} = {1'b1, 6'(i * 5), 8'($urandom)};
      @(negedge clk);
      wr_en = 1'b0;
      rd_idx = 6'(i * 5);
    end
    // one request, one refused during the stretch, then a held request that retriggers
    @(negedge clk);
    rq = 1'b1;
    @(negedge clk);
    rq = 1'b0;
    repeat (5) @(negedge clk);
    rq = 1'b1;
    @(negedge clk);
    rq = 1'b0;
    repeat (15) @(negedge clk);
    rq = 1'b1;
    repeat (20) @(negedge clk);
    rq = 1'b0;
    repeat (40) @(negedge clk);
    report_and_stop();
  end
endmodule // core_integration_config_tb
